// File: rtl/flash_cfg_pkg.sv
// Constants used by the command-behaviour configuration registers; the erase sequencer uses none of them.
package flash_cfg_pkg;

  // ****************************************
  // Command opcodes
  // ****************************************
  localparam logic [7:0] OP_GENERIC_REGISTER_READ = 8'h65;
  localparam logic [7:0] OP_GENERIC_REGISTER_WRITE = 8'h71;
  localparam logic [7:0] OP_SET_BURST_LENGTH_CMD = 8'hc0;
  localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
  localparam logic [7:0] OP_RESET = 8'h99;
  localparam logic [7:0] OP_LEGACY_RESET = 8'hf0;
  localparam logic [7:0] OP_RESUME_OR_CLEAR = 8'h30;
  localparam logic [7:0] OP_PARAM_ERASE_3B = 8'h20;
  localparam logic [7:0] OP_PARAM_ERASE_4B = 8'h21;
  localparam logic [7:0] OP_SECTOR_ERASE_3B = 8'hd8;
  localparam logic [7:0] OP_SECTOR_ERASE_4B = 8'hdc;
  localparam logic [7:0] OP_BULK_ERASE_A = 8'h60;
  localparam logic [7:0] OP_BULK_ERASE_B = 8'hc7;

  // ****************************************
  // Register addresses
  // ****************************************
  localparam int ADDR_W = 24;
  localparam logic [23:0] ADDR_NONVOLATILE_COMMAND_OPTIONS = 24'h000004;
  localparam logic [23:0] ADDR_NONVOLATILE_WRAP_DRIVE_BOOT = 24'h000005;
  localparam logic [23:0] ADDR_VOLATILE_COMMAND_OPTIONS = 24'h800004;
  localparam logic [23:0] ADDR_VOLATILE_WRAP_SETTINGS = 24'h800005;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int BIT_BLANK_CHECK_ENABLE = 5;
  localparam int BIT_BUFFER_WRAP_SELECT = 4;
  localparam int BIT_PARAMETER_SECTOR_DISABLE = 3;
  localparam int BIT_RESUME_OPCODE_SELECT = 2;
  localparam int BIT_BLOCK_ERASE_SIZE = 1;
  localparam int BIT_LEGACY_RESET_ENABLE = 0;
  localparam int BIT_WRAP_DISABLE = 4;
  localparam int DRIVE_LSB = 5;
  localparam int WRAP_LEN_LSB = 0;

  // ****************************************
  // Reset values and writable masks
  // ****************************************
  localparam logic [7:0] CMD_OPTIONS_RESET = 8'h02;
  localparam logic [7:0] CMD_OPTIONS_MASK = 8'h3f;
  localparam logic [7:0] WRAP_DRIVE_RESET = 8'h10;
  localparam logic [7:0] WRAP_DRIVE_MASK = 8'hf3;
  localparam logic [2:0] DRIVE_FACTORY = 3'h0;
  localparam logic [2:0] DRIVE_FACTORY_EQUIV = 3'h3;
  localparam logic [6:0] WRAP_BYTES_MIN = 7'h08;

  // ****************************************
  // Erase kinds and sizes
  // ****************************************
  localparam logic [1:0] ERASE_PARAM = 2'h0;
  localparam logic [1:0] ERASE_SECTOR = 2'h1;
  localparam logic [1:0] ERASE_BULK = 2'h2;
  localparam int SECTOR_KBYTES = 256;

endpackage : flash_cfg_pkg

// File: rtl/erase_blank_check.sv
// Erase sequencer with optional erase-status check and blank read before the erase.
`timescale 1ns/1ps

module erase_blank_check (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Request
  input wire logic start,
  input wire logic blank_check_enable,
  output logic busy,
  output logic done,
  output logic erased,
  // Array handshakes
  output logic status_req,
  input wire logic status_ack,
  input wire logic status_ok,
  output logic blank_req,
  input wire logic blank_ack,
  input wire logic blank_zero_found,
  output logic erase_req,
  input wire logic erase_ack
);

  typedef enum logic [3:0] {
    S_IDLE = 4'h1,
    S_STATUS = 4'h2,
    S_BLANK = 4'h4,
    S_ERASE = 4'h8
  } seq_state_e;

  typedef struct packed {
    seq_state_e st;
    logic status_req;
    logic blank_req;
    logic erase_req;
    logic busy;
    logic done;
    logic erased;
  } seq_s;

  localparam seq_s SEQ_RESET = '{st: S_IDLE, default: 1'b0};

  seq_s r;
  seq_s n;

  always_comb begin
    n = r;
    n.done = 1'b0;
    n.erased = 1'b0;
    case (r.st)
      S_IDLE: begin
        if (start) begin
          n.busy = 1'b1;
          if (blank_check_enable) begin
            n.st = S_STATUS;
            n.status_req = 1'b1;
          end else begin
            n.st = S_ERASE;
            n.erase_req = 1'b1;
          end
        end
      end
      S_STATUS: begin
        if (status_ack) begin
          n.status_req = 1'b0;
          if (status_ok) begin
            n.st = S_BLANK;
            n.blank_req = 1'b1;
          end else begin
            n.st = S_ERASE;
            n.erase_req = 1'b1;
          end
        end
      end
      S_BLANK: begin
        if (blank_ack) begin
          n.blank_req = 1'b0;
          if (blank_zero_found) begin
            n.st = S_ERASE;
            n.erase_req = 1'b1;
          end else begin
            n.st = S_IDLE;
            n.busy = 1'b0;
            n.done = 1'b1;
          end
        end
      end
      S_ERASE: begin
        if (erase_ack) begin
          n.erase_req = 1'b0;
          n.st = S_IDLE;
          n.busy = 1'b0;
          n.done = 1'b1;
          n.erased = 1'b1;
        end
      end
      default: n = SEQ_RESET;
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      r <= SEQ_RESET;
    end else begin
      r <= n;
    end
  end

  assign busy = r.busy;
  assign done = r.done;
  assign erased = r.erased;
  assign status_req = r.status_req;
  assign blank_req = r.blank_req;
  assign erase_req = r.erase_req;

  // ****************************************
  // Checks
  // ****************************************
  no_check_erase_a: assert property (@(posedge clock) disable iff (srst)
    (r.st == S_IDLE && start && !blank_check_enable) |=> erase_req && !status_req && !blank_req)
    else $error("erase without blank check did not start at once");

  failed_status_erase_a: assert property (@(posedge clock) disable iff (srst)
    (r.st == S_STATUS && status_ack && !status_ok) |=> erase_req && !blank_req)
    else $error("failed earlier erase did not erase unconditionally");

  zero_found_erase_a: assert property (@(posedge clock) disable iff (srst)
    (r.st == S_BLANK && blank_ack && blank_zero_found) |=> erase_req)
    else $error("programmed zero did not start the erase");

  blank_skip_a: assert property (@(posedge clock) disable iff (srst)
    (r.st == S_BLANK && blank_ack && !blank_zero_found) |=> done && !erased && !erase_req)
    else $error("blank sector was erased or not completed");

endmodule : erase_blank_check

// File: rtl/flash_behaviour_config_regs.sv
// Command-behaviour configuration registers with reset reload and decoded command effects.
`timescale 1ns/1ps

// Contract
// - Registers are read by command 65h and written by command 71h.
// - Power-on, hardware and software reset reload volatile bits from non-volatile ones.
// - Blank check on: a sector whose last erase failed is erased unconditionally.
// - Blank check on, last erase good: first programmed zero starts the erase.
// - Blank check on and no zero found: erase is skipped and completes.
// - Blank check applies to parameter, sector and bulk erase.
// - Blank check off: every erase starts at once without check.
// - Buffer wrap select 0 wraps past offset 255; 1 uses all 512 bytes.
// - Parameter-sector bit 0 keeps 4-kB sectors; 1 makes all sectors uniform.
// - Volatile parameter-sector bit is read-only and mirrors the non-volatile one.
// - Resume select 1 makes 30h resume; 0 makes it clear status.
// - Block erase size bit ignored; D8h and DCh always erase 256-kB sectors.
// - Reset sequence 66h then 99h is always accepted.
// - F0h resets only when legacy reset enable is 1, else ignored.
// - Burst wrap applies only to main array reads, never registers or OTP.
// - Resets copy non-volatile wrap and drive settings into volatile wrap register.
// - Set burst length C0h also writes the volatile wrap register.
// - Wrap enable is active low, only quad reads wrap, default sequential.
// - Wrap length 00..11 selects 8, 16, 32, 64 byte bursts, default 00.
// - Drive code selects boot strength; code 000 equals code 011.
module flash_behaviour_config_regs #(
  parameter int ADDR_WIDTH = 24
) (
  // Clock and resets
  input wire logic clock,
  input wire logic srst,
  input wire logic hw_reset_n,
  // Decoded command port
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_opcode,
  input wire logic [ADDR_WIDTH-1:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  output logic rd_valid,
  output logic [7:0] rd_data,
  // Command effects
  output logic soft_reset_pulse,
  output logic resume_pulse,
  output logic clear_status_pulse,
  // Program buffer
  input wire logic [8:0] prog_load_offset,
  output logic [8:0] prog_buf_index,
  // Read path and pads
  input wire logic read_quad_array,
  output logic burst_wrap_active,
  output logic [6:0] burst_wrap_bytes,
  output logic [2:0] drive_strength,
  output logic param_sectors_present,
  // Erase request to the array
  output logic [1:0] erase_kind,
  output logic [ADDR_WIDTH-1:0] erase_addr,
  output logic erase_busy,
  output logic erase_done,
  output logic erase_performed,
  output logic status_req,
  input wire logic status_ack,
  input wire logic status_ok,
  output logic blank_req,
  input wire logic blank_ack,
  input wire logic blank_zero_found,
  output logic erase_req,
  input wire logic erase_ack
);

  initial begin
    if (ADDR_WIDTH != flash_cfg_pkg::ADDR_W) begin
      $error("ADDR_WIDTH must match the register address width");
    end
  end

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [7:0] cmd_nv;
    logic [7:0] cmd_v;
    logic [7:0] wrap_nv;
    logic [7:0] wrap_v;
    logic rd_valid;
    logic [7:0] rd_data;
    logic reset_armed;
    logic soft_reset;
    logic resume;
    logic clear_status;
    logic hw_s1;
    logic hw_s2;
    logic hw_s3;
    logic hw_level;
    logic [8:0] prog_index;
    logic wrap_active;
    logic [6:0] wrap_bytes;
    logic [2:0] drive;
    logic param_present;
    logic erase_go;
    logic [1:0] erase_kind;
    logic [ADDR_WIDTH-1:0] erase_addr;
  } cfg_s;

  localparam cfg_s CFG_RESET = '{
    cmd_nv: flash_cfg_pkg::CMD_OPTIONS_RESET,
    cmd_v: flash_cfg_pkg::CMD_OPTIONS_RESET,
    wrap_nv: flash_cfg_pkg::WRAP_DRIVE_RESET,
    wrap_v: flash_cfg_pkg::WRAP_DRIVE_RESET,
    hw_s1: 1'b1,
    hw_s2: 1'b1,
    hw_s3: 1'b1,
    hw_level: 1'b1,
    wrap_bytes: flash_cfg_pkg::WRAP_BYTES_MIN,
    drive: flash_cfg_pkg::DRIVE_FACTORY_EQUIV,
    param_present: 1'b1,
    default: '0
  };

  cfg_s r;
  cfg_s n;
  logic reload;
  logic take;
  logic seq_busy;

  // ****************************************
  // Decode helpers
  // ****************************************
  function automatic logic [7:0] read_reg(input cfg_s s, input logic [ADDR_WIDTH-1:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      flash_cfg_pkg::ADDR_NONVOLATILE_COMMAND_OPTIONS: v = s.cmd_nv;
      flash_cfg_pkg::ADDR_VOLATILE_COMMAND_OPTIONS: v = s.cmd_v;
      flash_cfg_pkg::ADDR_NONVOLATILE_WRAP_DRIVE_BOOT: v = s.wrap_nv;
      flash_cfg_pkg::ADDR_VOLATILE_WRAP_SETTINGS: v = s.wrap_v;
      default: v = 8'h00;
    endcase
    return v;
  endfunction : read_reg

  // Code 000 is the factory setting and drives like 011.
  function automatic logic [2:0] boot_drive(input logic [7:0] w);
    logic [2:0] c;
    c = w[flash_cfg_pkg::DRIVE_LSB +: 3];
    if (c == flash_cfg_pkg::DRIVE_FACTORY) begin
      c = flash_cfg_pkg::DRIVE_FACTORY_EQUIV;
    end
    return c;
  endfunction : boot_drive

  function automatic logic is_erase(input logic [7:0] op);
    return op == flash_cfg_pkg::OP_PARAM_ERASE_3B || op == flash_cfg_pkg::OP_PARAM_ERASE_4B ||
      op == flash_cfg_pkg::OP_SECTOR_ERASE_3B || op == flash_cfg_pkg::OP_SECTOR_ERASE_4B ||
      op == flash_cfg_pkg::OP_BULK_ERASE_A || op == flash_cfg_pkg::OP_BULK_ERASE_B;
  endfunction : is_erase

  // ****************************************
  // Next state
  // ****************************************
  // The registered soft reset and a filtered low hardware reset both reload next cycle.
  assign reload = r.soft_reset || !r.hw_level;
  assign take = cmd_valid && !reload;

  always_comb begin
    n = r;
    n.rd_valid = 1'b0;
    n.soft_reset = 1'b0;
    n.resume = 1'b0;
    n.clear_status = 1'b0;
    n.erase_go = 1'b0;
    n.hw_s1 = hw_reset_n;
    n.hw_s2 = r.hw_s1;
    n.hw_s3 = r.hw_s2;
    if (r.hw_s2 == r.hw_s3) begin
      n.hw_level = r.hw_s3;
    end
    if (reload) begin
      n.cmd_v = r.cmd_nv;
      n.wrap_v = r.wrap_nv;
      n.drive = boot_drive(r.wrap_nv);
      n.reset_armed = 1'b0;
    end else if (take) begin
      n.reset_armed = (cmd_opcode == flash_cfg_pkg::OP_RESET_ENABLE);
      case (cmd_opcode)
        flash_cfg_pkg::OP_GENERIC_REGISTER_READ: begin
          n.rd_valid = 1'b1;
          n.rd_data = read_reg(r, cmd_addr);
        end
        flash_cfg_pkg::OP_GENERIC_REGISTER_WRITE: begin
          case (cmd_addr)
            flash_cfg_pkg::ADDR_NONVOLATILE_COMMAND_OPTIONS: begin
              n.cmd_nv = cmd_wdata & flash_cfg_pkg::CMD_OPTIONS_MASK;
              // Only the parameter-sector bit of the volatile copy follows this write.
              n.cmd_v[flash_cfg_pkg::BIT_PARAMETER_SECTOR_DISABLE] =
                cmd_wdata[flash_cfg_pkg::BIT_PARAMETER_SECTOR_DISABLE];
            end
            flash_cfg_pkg::ADDR_VOLATILE_COMMAND_OPTIONS: begin
              // Writes to the mirrored bit are dropped so the mirror cannot diverge.
              n.cmd_v = (cmd_wdata & flash_cfg_pkg::CMD_OPTIONS_MASK &
                ~(8'h01 << flash_cfg_pkg::BIT_PARAMETER_SECTOR_DISABLE)) |
                (r.cmd_v & (8'h01 << flash_cfg_pkg::BIT_PARAMETER_SECTOR_DISABLE));
            end
            flash_cfg_pkg::ADDR_NONVOLATILE_WRAP_DRIVE_BOOT: begin
              n.wrap_nv = cmd_wdata & flash_cfg_pkg::WRAP_DRIVE_MASK;
            end
            flash_cfg_pkg::ADDR_VOLATILE_WRAP_SETTINGS: begin
              n.wrap_v = cmd_wdata & flash_cfg_pkg::WRAP_DRIVE_MASK;
            end
            default: begin
            end
          endcase
        end
        flash_cfg_pkg::OP_SET_BURST_LENGTH_CMD: begin
          n.wrap_v = cmd_wdata & flash_cfg_pkg::WRAP_DRIVE_MASK;
        end
        flash_cfg_pkg::OP_RESET: begin
          n.soft_reset = r.reset_armed;
        end
        flash_cfg_pkg::OP_LEGACY_RESET: begin
          n.soft_reset = r.cmd_v[flash_cfg_pkg::BIT_LEGACY_RESET_ENABLE];
        end
        flash_cfg_pkg::OP_RESUME_OR_CLEAR: begin
          n.resume = r.cmd_v[flash_cfg_pkg::BIT_RESUME_OPCODE_SELECT];
          n.clear_status = !r.cmd_v[flash_cfg_pkg::BIT_RESUME_OPCODE_SELECT];
        end
        default: begin
          // Erase commands arriving while one runs are dropped.
          if (is_erase(cmd_opcode) && !seq_busy && !r.erase_go) begin
            n.erase_go = 1'b1;
            n.erase_addr = cmd_addr;
            if (cmd_opcode == flash_cfg_pkg::OP_PARAM_ERASE_3B ||
                cmd_opcode == flash_cfg_pkg::OP_PARAM_ERASE_4B) begin
              n.erase_kind = flash_cfg_pkg::ERASE_PARAM;
            end else if (cmd_opcode == flash_cfg_pkg::OP_SECTOR_ERASE_3B ||
                         cmd_opcode == flash_cfg_pkg::OP_SECTOR_ERASE_4B) begin
              n.erase_kind = flash_cfg_pkg::ERASE_SECTOR;
            end else begin
              n.erase_kind = flash_cfg_pkg::ERASE_BULK;
            end
          end
        end
      endcase
    end
    if (r.cmd_v[flash_cfg_pkg::BIT_BUFFER_WRAP_SELECT]) begin
      n.prog_index = prog_load_offset;
    end else begin
      n.prog_index = {1'b0, prog_load_offset[7:0]};
    end
    n.param_present = !r.cmd_v[flash_cfg_pkg::BIT_PARAMETER_SECTOR_DISABLE];
    n.wrap_active = read_quad_array && !r.wrap_v[flash_cfg_pkg::BIT_WRAP_DISABLE];
    n.wrap_bytes = flash_cfg_pkg::WRAP_BYTES_MIN <<
      r.wrap_v[flash_cfg_pkg::WRAP_LEN_LSB +: 2];
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      r <= CFG_RESET;
    end else begin
      r <= n;
    end
  end

  // ****************************************
  // Erase sequencer
  // ****************************************
  erase_blank_check u_erase (
    .clock(clock),
    .srst(srst),
    .start(r.erase_go),
    .blank_check_enable(r.cmd_v[flash_cfg_pkg::BIT_BLANK_CHECK_ENABLE]),
    .busy(seq_busy),
    .done(erase_done),
    .erased(erase_performed),
    .status_req(status_req),
    .status_ack(status_ack),
    .status_ok(status_ok),
    .blank_req(blank_req),
    .blank_ack(blank_ack),
    .blank_zero_found(blank_zero_found),
    .erase_req(erase_req),
    .erase_ack(erase_ack)
  );

  assign erase_busy = seq_busy;
  assign rd_valid = r.rd_valid;
  assign rd_data = r.rd_data;
  assign soft_reset_pulse = r.soft_reset;
  assign resume_pulse = r.resume;
  assign clear_status_pulse = r.clear_status;
  assign prog_buf_index = r.prog_index;
  assign burst_wrap_active = r.wrap_active;
  assign burst_wrap_bytes = r.wrap_bytes;
  assign drive_strength = r.drive;
  assign param_sectors_present = r.param_present;
  assign erase_kind = r.erase_kind;
  assign erase_addr = r.erase_addr;

  // ****************************************
  // Checks
  // ****************************************
  read_answer_a: assert property (@(posedge clock) disable iff (srst)
    take && cmd_opcode == flash_cfg_pkg::OP_GENERIC_REGISTER_READ |=>
      rd_valid && rd_data == read_reg($past(r), $past(cmd_addr)))
    else $error("register read answer wrong or missing");

  reset_reload_a: assert property (@(posedge clock) disable iff (srst)
    reload |=> r.cmd_v == $past(r.cmd_nv) && r.wrap_v == $past(r.wrap_nv))
    else $error("reset did not reload volatile copies");

  param_mirror_a: assert property (@(posedge clock) disable iff (srst)
    r.cmd_v[flash_cfg_pkg::BIT_PARAMETER_SECTOR_DISABLE] ==
      r.cmd_nv[flash_cfg_pkg::BIT_PARAMETER_SECTOR_DISABLE])
    else $error("volatile parameter-sector bit diverged");

  opcode30_decode_a: assert property (@(posedge clock) disable iff (srst)
    take && cmd_opcode == flash_cfg_pkg::OP_RESUME_OR_CLEAR |=>
      resume_pulse == $past(r.cmd_v[flash_cfg_pkg::BIT_RESUME_OPCODE_SELECT]) &&
      clear_status_pulse != resume_pulse)
    else $error("opcode 30h decoded wrongly");

  two_step_reset_a: assert property (@(posedge clock) disable iff (srst)
    take && cmd_opcode == flash_cfg_pkg::OP_RESET_ENABLE ##1 !cmd_valid ##1
      take && cmd_opcode == flash_cfg_pkg::OP_RESET |=> soft_reset_pulse && reload)
    else $error("reset sequence not honoured");

  legacy_ignore_a: assert property (@(posedge clock) disable iff (srst)
    take && cmd_opcode == flash_cfg_pkg::OP_LEGACY_RESET &&
      !r.cmd_v[flash_cfg_pkg::BIT_LEGACY_RESET_ENABLE] |=> !soft_reset_pulse)
    else $error("disabled single-opcode reset acted");

  buffer_wrap_a: assert property (@(posedge clock) disable iff (srst)
    !r.cmd_v[flash_cfg_pkg::BIT_BUFFER_WRAP_SELECT] |=>
      prog_buf_index == {1'b0, $past(prog_load_offset[7:0])})
    else $error("program buffer index did not wrap at 256");

  array_only_wrap_a: assert property (@(posedge clock) disable iff (srst)
    !read_quad_array |=> !burst_wrap_active)
    else $error("burst wrap outside quad array reads");

  burst_length_a: assert property (@(posedge clock) disable iff (srst)
    take && cmd_opcode == flash_cfg_pkg::OP_SET_BURST_LENGTH_CMD |=>
      r.wrap_v == ($past(cmd_wdata) & flash_cfg_pkg::WRAP_DRIVE_MASK))
    else $error("set burst length did not write the wrap register");

  reserved_zero_a: assert property (@(posedge clock) disable iff (srst)
    (r.cmd_v & ~flash_cfg_pkg::CMD_OPTIONS_MASK) == 8'h00 &&
      (r.wrap_v & ~flash_cfg_pkg::WRAP_DRIVE_MASK) == 8'h00)
    else $error("reserved bits not zero");

  drive_nonzero_a: assert property (@(posedge clock) disable iff (srst)
    drive_strength != flash_cfg_pkg::DRIVE_FACTORY)
    else $error("factory drive code not mapped");

endmodule : flash_behaviour_config_regs

// File: sim/cmd_host_model.sv
// Command host and array responder facing the configuration registers.
`timescale 1ns/1ps

module cmd_host_model (
  // Clock
  input wire logic clock,
  // Command port
  output logic cmd_valid,
  output logic [7:0] cmd_opcode,
  output logic [23:0] cmd_addr,
  output logic [7:0] cmd_wdata,
  // Array handshakes
  input wire logic status_req,
  output logic status_ack,
  output logic status_ok,
  input wire logic blank_req,
  output logic blank_ack,
  output logic blank_zero_found,
  input wire logic erase_req,
  output logic erase_ack
);
  logic ok_v = 1'b1;
  logic zero_v = 1'b0;
  int n_blank = 0;

  initial begin
    {cmd_valid, cmd_opcode, cmd_addr, cmd_wdata} = '0;
    {status_ack, blank_ack, erase_ack} = '0;
  end

  // Answers are only valid with their ack; otherwise the inverse is shown so stale use shows up.
  assign status_ok = status_ack ? ok_v : ~ok_v;
  assign blank_zero_found = blank_ack ? zero_v : ~zero_v;

  always @(posedge clock) begin
    status_ack <= #1 status_req & ~status_ack;
    blank_ack <= #1 blank_req & ~blank_ack;
    erase_ack <= #1 erase_req & ~erase_ack;
    if (blank_ack) begin
      n_blank <= n_blank + 1;
    end
  end

  task automatic send(input logic [7:0] op, input logic [23:0] a, input logic [7:0] d);
    @(posedge clock);
    #1;
    cmd_valid = 1'b1;
    cmd_opcode = op;
    cmd_addr = a;
    cmd_wdata = d;
    @(posedge clock);
    #1;
    cmd_valid = 1'b0;
    cmd_addr = ~a;
  endtask : send
endmodule : cmd_host_model

// File: sim/tb_flash_behaviour_config_regs.sv
// Self-checking bench for the command-behaviour configuration registers.
`timescale 1ns/1ps

module tb_flash_behaviour_config_regs;
  typedef struct packed {logic [7:0] op; logic [23:0] a; logic [7:0] d; logic [7:0] e;} row_s;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic hw_reset_n = 1'b1;
  logic [8:0] prog_load_offset = 9'h12c;
  logic read_quad_array = 1'b1;
  logic cmd_valid, rd_valid, soft_reset_pulse, resume_pulse, clear_status_pulse;
  logic [7:0] cmd_opcode, cmd_wdata, rd_data;
  logic [23:0] cmd_addr, erase_addr;
  logic [8:0] prog_buf_index;
  logic [6:0] burst_wrap_bytes;
  logic [2:0] drive_strength;
  logic [1:0] erase_kind;
  logic burst_wrap_active, param_sectors_present, erase_busy, erase_done, erase_performed;
  logic status_req, status_ack, status_ok, blank_req, blank_ack, blank_zero_found;
  logic erase_req, erase_ack;
  int n_errors = 0;
  int checks_done = 0;
  row_s rows [10] = '{
    '{8'h65, 24'h000004, 8'h00, 8'h02}, '{8'h65, 24'h800004, 8'h00, 8'h02},
    '{8'h65, 24'h000005, 8'h00, 8'h10}, '{8'h65, 24'h800005, 8'h00, 8'h10},
    '{8'h71, 24'h800004, 8'hf7, 8'h37}, '{8'h71, 24'h000004, 8'hff, 8'h3f},
    '{8'h71, 24'h800005, 8'hff, 8'hf3}, '{8'hc0, 24'h800005, 8'h03, 8'h03},
    '{8'h71, 24'h000005, 8'h00, 8'h00}, '{8'h71, 24'h123456, 8'hff, 8'h00}};

  flash_behaviour_config_regs dut_u (.clock, .srst, .hw_reset_n, .cmd_valid, .cmd_opcode,
    .cmd_addr, .cmd_wdata, .rd_valid, .rd_data, .soft_reset_pulse, .resume_pulse,
    .clear_status_pulse, .prog_load_offset, .prog_buf_index, .read_quad_array,
    .burst_wrap_active, .burst_wrap_bytes, .drive_strength, .param_sectors_present, .erase_kind,
    .erase_addr, .erase_busy, .erase_done, .erase_performed, .status_req, .status_ack,
    .status_ok, .blank_req, .blank_ack, .blank_zero_found, .erase_req, .erase_ack);

  cmd_host_model host_u (.clock, .cmd_valid, .cmd_opcode, .cmd_addr, .cmd_wdata, .status_req,
    .status_ack, .status_ok, .blank_req, .blank_ack, .blank_zero_found, .erase_req, .erase_ack);

  initial begin
    forever #2 clock = ~clock;
  end

  task automatic chk(input string n, input logic [8:0] e, input logic [8:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic rd(input logic [23:0] a, input logic [7:0] e);
    host_u.send(8'h65, a, 8'h00);
    chk("rd_valid", 9'h1, {8'h00, rd_valid});
    chk("rd_data", {1'b0, e}, {1'b0, rd_data});
  endtask : rd

  task automatic pulses(input logic [7:0] op, input logic [2:0] e);
    host_u.send(op, 24'h000000, 8'h00);
    chk("pulses", {6'h00, e}, {6'h00, soft_reset_pulse, resume_pulse, clear_status_pulse});
    repeat (2) @(posedge clock);
  endtask : pulses

  task automatic erase(input logic [7:0] op, input logic ok, input logic z, input int nb,
      input logic [1:0] k);
    int i;
    host_u.ok_v = ok;
    host_u.zero_v = z;
    host_u.send(op, 24'h040000, 8'h00);
    for (i = 0; i < 40 && erase_done !== 1'b1; i++) @(posedge clock) #1;
    chk("erase_done", 9'h1, {8'h00, erase_done});
    chk("erase_performed", {8'h00, !(ok && !z && nb > 0)}, {8'h00, erase_performed});
    chk("erase_kind", {7'h00, k}, {7'h00, erase_kind});
    chk("blank_reads", nb[8:0], host_u.n_blank[8:0]);
    chk("erase_addr", 9'h008, erase_addr[23:15]);
    chk("erase_busy", 9'h0, {8'h00, erase_busy});
  endtask : erase

  task automatic results;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results

  initial begin
    #(4 * 5000);
    n_errors++;
    results();
  end

  initial begin
    repeat (10) @(posedge clock);
    #1;
    srst = 1'b0;
    @(posedge clock) #1;
    chk("boot_outputs", 9'h0e2, {drive_strength, param_sectors_present, burst_wrap_bytes[6:3],
      burst_wrap_active});
    for (int r = 0; r < 10; r++) begin
      host_u.send(rows[r].op, rows[r].a, rows[r].d);
      rd(rows[r].a, rows[r].e);
    end
    chk("wrap_64", 9'h040, {2'h0, burst_wrap_bytes});
    chk("wrap_on", 9'h1, {8'h00, burst_wrap_active});
    chk("uniform", 9'h0, {8'h00, param_sectors_present});
    chk("buf_512", 9'h12c, prog_buf_index);
    pulses(8'h30, 3'b010);
    erase(8'h20, 1'b1, 1'b0, 1, 2'h0);
    erase(8'h60, 1'b1, 1'b1, 2, 2'h2);
    erase(8'hd8, 1'b0, 1'b0, 2, 2'h1);
    pulses(8'hf0, 3'b100);
    rd(24'h800005, 8'h00);
    rd(24'h800004, 8'h3f);
    chk("drive_equiv", 9'h003, {6'h00, drive_strength});
    host_u.send(8'h71, 24'h800004, 8'h08);
    pulses(8'h30, 3'b001);
    pulses(8'hf0, 3'b000);
    chk("buf_256", 9'h02c, prog_buf_index);
    erase(8'hdc, 1'b1, 1'b1, 2, 2'h1);
    host_u.send(8'h66, 24'h000000, 8'h00);
    pulses(8'h99, 3'b100);
    rd(24'h800004, 8'h3f);
    read_quad_array = 1'b0;
    repeat (2) @(posedge clock);
    #1;
    chk("no_wrap", 9'h0, {8'h00, burst_wrap_active});
    // Hardware reset pin: volatile options must come back from the non-volatile copy.
    host_u.send(8'h71, 24'h800004, 8'h08);
    hw_reset_n = 1'b0;
    repeat (8) @(posedge clock);
    #1;
    hw_reset_n = 1'b1;
    repeat (8) @(posedge clock);
    rd(24'h800004, 8'h3f);
    // Power-on reset in mid-run restores the factory non-volatile values.
    srst = 1'b1;
    repeat (2) @(posedge clock);
    #1;
    srst = 1'b0;
    rd(24'h000004, 8'h02);
    results();
  end
endmodule : tb_flash_behaviour_config_regs
